/* core/cache_ctrl.sv */
// instruction and data cache control: tags, lock, cacheability, byte order
////////////////////////////////////////////////////////////////////////////////
// Contract
// - icache is 2, 4 or 16 KB
// - purge command invalidates whole icache
// - lock command fills from operand address
// - locked code at most half; rest direct-mapped
// - dcache is 1, 2 or 4 KB
// - region cacheable bit decides data caching
// - atomic accesses never cached
// - dcache global enable, disable, invalidate
// - single-processor coherency, no snooping
// - unaligned split; each piece judged alone
// - correct data for both byte orders
// - region config sets width, order, caching
module cache_ctrl #(
  parameter int ICACHE_BYTES = cache_ctrl_pkg::ICACHE_BYTES_DEFAULT,
  parameter int DCACHE_BYTES = cache_ctrl_pkg::DCACHE_BYTES_DEFAULT
) (
  input wire logic clk,
  input wire logic srst,
  // instruction cache command and lookup
  input wire logic ic_cmd_valid,
  input wire cache_ctrl_pkg::ic_cmd_type ic_cmd,
  input wire logic [cache_ctrl_pkg::ADDR_W-1:0] ic_cmd_addr,
  output logic ic_busy,
  input wire logic ic_fetch_valid,
  input wire logic [cache_ctrl_pkg::ADDR_W-1:0] ic_fetch_addr,
  output logic ic_hit,
  output logic ic_lookup_done,
  output logic ic_fill_req,
  output logic [cache_ctrl_pkg::ADDR_W-1:0] ic_fill_addr,
  input wire logic ic_fill_done,
  output logic ic_locked,
  // data cache command and access
  input wire logic dc_cmd_valid,
  input wire cache_ctrl_pkg::dc_cmd_type dc_cmd,
  output logic dc_enabled,
  input wire logic [cache_ctrl_pkg::REGIONS*cache_ctrl_pkg::CFG_W-1:0] physical_region_config,
  input wire logic [cache_ctrl_pkg::REGIONS*cache_ctrl_pkg::CFG_W-1:0] logical_region_config,
  input wire logic dc_acc_valid,
  input wire logic [cache_ctrl_pkg::ADDR_W-1:0] dc_acc_addr,
  input wire logic dc_acc_atomic,
  input wire logic dc_acc_aligned,
  input wire logic dc_fill_valid,
  input wire logic [cache_ctrl_pkg::ADDR_W-1:0] dc_fill_addr,
  input wire logic [cache_ctrl_pkg::DATA_W-1:0] dc_raw_data,
  output logic dc_cacheable,
  output logic dc_hit,
  output logic dc_big_endian,
  output logic [1:0] dc_bus_width,
  output logic dc_split,
  output logic [cache_ctrl_pkg::DATA_W-1:0] dc_data
);
  localparam int LB = cache_ctrl_pkg::LINE_BYTES;
  localparam int IC_LINES = ICACHE_BYTES / LB;
  localparam int IC_IDX_W = $clog2(IC_LINES);
  localparam int IC_HALF_W = IC_IDX_W - 1;
  localparam int OFF_W = $clog2(LB);
  localparam int DC_LINES = DCACHE_BYTES / LB;
  localparam int DC_IDX_W = $clog2(DC_LINES);
  localparam int AW = cache_ctrl_pkg::ADDR_W;
  localparam int RW = cache_ctrl_pkg::REGION_W;
  localparam int CW = cache_ctrl_pkg::CFG_W;

  if (ICACHE_BYTES != 2048 && ICACHE_BYTES != 4096 && ICACHE_BYTES != 16384) begin : g_bad_icache
    $error("cache_ctrl: ICACHE_BYTES must be 2, 4 or 16 KB");
  end
  if (DCACHE_BYTES != 1024 && DCACHE_BYTES != 2048 && DCACHE_BYTES != 4096) begin : g_bad_dcache
    $error("cache_ctrl: DCACHE_BYTES must be 1, 2 or 4 KB");
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction cache control
  typedef enum logic [1:0] {IC_IDLE, IC_LOCK_FILL, IC_LOCK_WAIT} ic_state_type;
  ic_state_type ic_state_r;
  logic [IC_HALF_W-1:0] lock_cnt_r;
  logic [AW-1:0] lock_base_r;
  logic ic_locked_r;
  logic [AW-1:0] lock_lo_r;
  logic [AW-1:0] lock_hi_r;
  logic ic_purge;
  logic ic_in_lock;
  logic [IC_IDX_W-1:0] ic_fetch_idx;
  logic [IC_IDX_W-1:0] ic_set_idx;
  logic ic_set_en;
  logic ic_rd_valid;
  logic [AW-1:0] ic_tag_r [IC_LINES];
  logic [AW-1:0] ic_fetch_q;
  logic ic_fetch_q_valid;
  logic [IC_IDX_W-1:0] ic_fetch_idx_q;

  // purge also drops any lock so refetched code is consistent
  assign ic_purge = ic_cmd_valid && ic_state_r == IC_IDLE && ic_cmd == cache_ctrl_pkg::IC_CMD_PURGE;
  assign ic_in_lock = ic_locked_r && ic_fetch_addr >= lock_lo_r && ic_fetch_addr < lock_hi_r;
  // locked code lives in the low half; while a lock is held everything else maps into the upper half
  assign ic_fetch_idx = ic_in_lock ? {1'b0, ic_fetch_addr[OFF_W +: IC_HALF_W]}
                                   : (ic_locked_r ? {1'b1, ic_fetch_addr[OFF_W +: IC_HALF_W]}
                                                  : ic_fetch_addr[OFF_W +: IC_IDX_W]);
  assign ic_set_en = (ic_state_r == IC_LOCK_WAIT && ic_fill_done)
                     || (ic_state_r == IC_IDLE && ic_fill_done && ic_fetch_q_valid && !ic_hit);
  // index from the line address itself, so a lock base off a half-cache boundary still lines up
  assign ic_set_idx = (ic_state_r == IC_LOCK_WAIT) ? {1'b0, ic_fill_addr[OFF_W +: IC_HALF_W]}
                                                   : ic_fetch_idx_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      ic_state_r <= IC_IDLE;
      lock_cnt_r <= '0;
      lock_base_r <= '0;
    end else begin
      case (ic_state_r)
        IC_IDLE: begin
          if (ic_cmd_valid && ic_cmd == cache_ctrl_pkg::IC_CMD_LOCK) begin
            lock_base_r <= {ic_cmd_addr[AW-1:OFF_W], {OFF_W{1'b0}}};
            lock_cnt_r <= '0;
            ic_state_r <= IC_LOCK_FILL;
          end
        end
        IC_LOCK_FILL: ic_state_r <= IC_LOCK_WAIT;
        IC_LOCK_WAIT: begin
          if (ic_fill_done) begin
            lock_cnt_r <= lock_cnt_r + 1'b1;
            ic_state_r <= (&lock_cnt_r) ? IC_IDLE : IC_LOCK_FILL;
          end
        end
        default: ic_state_r <= IC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ic_locked_r <= 1'b0;
      lock_lo_r <= '0;
      lock_hi_r <= '0;
    end else if (ic_purge || (ic_cmd_valid && ic_state_r == IC_IDLE && ic_cmd == cache_ctrl_pkg::IC_CMD_UNLOCK)) begin
      ic_locked_r <= 1'b0;
    end else if (ic_state_r == IC_LOCK_WAIT && ic_fill_done && (&lock_cnt_r)) begin
      ic_locked_r <= 1'b1;
      lock_lo_r <= lock_base_r;
      lock_hi_r <= lock_base_r + AW'(ICACHE_BYTES / 2);
    end
  end

  always_ff @(posedge clk) begin
    if (ic_set_en) begin
      ic_tag_r[ic_set_idx] <= (ic_state_r == IC_LOCK_WAIT) ? ic_fill_addr : ic_fetch_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ic_fetch_q <= '0;
      ic_fetch_q_valid <= 1'b0;
      ic_fetch_idx_q <= '0;
    end else begin
      ic_fetch_q <= {ic_fetch_addr[AW-1:OFF_W], {OFF_W{1'b0}}};
      ic_fetch_idx_q <= ic_fetch_idx;
      ic_fetch_q_valid <= ic_fetch_valid && ic_state_r == IC_IDLE;
    end
  end

  // purge clears every valid bit; locked lines survive only through refill
  valid_bits #(.ENTRIES(IC_LINES), .IDX_W(IC_IDX_W)) u_ic_valid (
    .clk(clk),
    .srst(srst),
    .clear_all(ic_purge),
    .set_en(ic_set_en),
    .set_idx(ic_set_idx),
    .clr_en(1'b0),
    .clr_idx(ic_set_idx),
    .rd_idx(ic_fetch_idx),
    .rd_valid(ic_rd_valid)
  );

  logic [AW-1:0] ic_tag_q;
  always_ff @(posedge clk) begin
    ic_tag_q <= ic_tag_r[ic_fetch_idx];
  end

  assign ic_hit = ic_fetch_q_valid && ic_rd_valid && ic_tag_q == ic_fetch_q;
  assign ic_lookup_done = ic_fetch_q_valid;
  assign ic_busy = ic_state_r != IC_IDLE;
  assign ic_locked = ic_locked_r;
  assign ic_fill_req = (ic_state_r == IC_LOCK_FILL) || (ic_fetch_q_valid && !ic_hit);
  assign ic_fill_addr = (ic_state_r == IC_IDLE) ? ic_fetch_q
                        : lock_base_r + {{(AW-IC_HALF_W-OFF_W){1'b0}}, lock_cnt_r, {OFF_W{1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // data cache control
  logic dc_en_r;
  logic dc_inval;
  logic [RW-1:0] region;
  logic [CW-1:0] pcfg;
  logic [CW-1:0] lcfg;
  logic cacheable_now;
  logic dc_rd_valid;
  logic [AW-1:0] dc_tag_r [DC_LINES];
  logic [AW-1:0] dc_acc_q;
  logic dc_acc_q_valid;
  logic dc_cacheable_r;

  // logical config can only veto caching: both the physical and logical cacheable bits must be set
  assign region = dc_acc_addr[AW-1 -: RW];
  assign pcfg = physical_region_config[region*CW +: CW];
  assign lcfg = logical_region_config[region*CW +: CW];
  assign cacheable_now = dc_en_r && pcfg[cache_ctrl_pkg::CFG_CACHEABLE_BIT]
                         && lcfg[cache_ctrl_pkg::CFG_CACHEABLE_BIT]
                         && !dc_acc_atomic;
  assign dc_inval = dc_cmd_valid && dc_cmd == cache_ctrl_pkg::DC_CMD_INVALIDATE;

  always_ff @(posedge clk) begin
    if (srst) begin
      dc_en_r <= 1'b0;
    end else if (dc_cmd_valid && dc_cmd == cache_ctrl_pkg::DC_CMD_ENABLE) begin
      dc_en_r <= 1'b1;
    end else if (dc_cmd_valid && dc_cmd == cache_ctrl_pkg::DC_CMD_DISABLE) begin
      dc_en_r <= 1'b0;
    end
  end

  // only this processor's own fills touch the tags: no snoop port
  always_ff @(posedge clk) begin
    if (dc_fill_valid) begin
      dc_tag_r[dc_fill_addr[OFF_W +: DC_IDX_W]] <= {dc_fill_addr[AW-1:OFF_W], {OFF_W{1'b0}}};
    end
  end

  valid_bits #(.ENTRIES(DC_LINES), .IDX_W(DC_IDX_W)) u_dc_valid (
    .clk(clk),
    .srst(srst),
    .clear_all(dc_inval),
    .set_en(dc_fill_valid && !dc_inval),
    .set_idx(dc_fill_addr[OFF_W +: DC_IDX_W]),
    .clr_en(1'b0),
    .clr_idx(dc_fill_addr[OFF_W +: DC_IDX_W]),
    .rd_idx(dc_acc_addr[OFF_W +: DC_IDX_W]),
    .rd_valid(dc_rd_valid)
  );

  logic [AW-1:0] dc_tag_q;
  always_ff @(posedge clk) begin
    dc_tag_q <= dc_tag_r[dc_acc_addr[OFF_W +: DC_IDX_W]];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dc_acc_q <= '0;
      dc_acc_q_valid <= 1'b0;
      dc_cacheable_r <= 1'b0;
      dc_big_endian <= 1'b0;
      dc_bus_width <= '0;
      dc_split <= 1'b0;
    end else begin
      dc_acc_q <= {dc_acc_addr[AW-1:OFF_W], {OFF_W{1'b0}}};
      dc_acc_q_valid <= dc_acc_valid;
      // each aligned piece is judged on its own, so pieces may mix hit and miss
      dc_cacheable_r <= dc_acc_valid && cacheable_now;
      dc_split <= dc_acc_valid && !dc_acc_aligned;
      dc_big_endian <= pcfg[cache_ctrl_pkg::CFG_BIG_ENDIAN_BIT];
      dc_bus_width <= pcfg[cache_ctrl_pkg::CFG_WIDTH_LSB +: 2];
    end
  end

  // stored data stay in little-endian order; swap on the way out if needed
  always_ff @(posedge clk) begin
    if (srst) begin
      dc_data <= '0;
    end else if (pcfg[cache_ctrl_pkg::CFG_BIG_ENDIAN_BIT]) begin
      dc_data <= {dc_raw_data[7:0], dc_raw_data[15:8], dc_raw_data[23:16], dc_raw_data[31:24]};
    end else begin
      dc_data <= dc_raw_data;
    end
  end

  assign dc_cacheable = dc_cacheable_r;
  // a pending invalidate, or a disable already taken, turns a late hit into a miss
  assign dc_hit = dc_acc_q_valid && dc_cacheable_r && dc_rd_valid && dc_en_r && !dc_inval
                  && dc_tag_q == dc_acc_q;
  assign dc_enabled = dc_en_r;
endmodule

/* core/cache_ctrl_pkg.sv */
// constants and types shared by the cache control block
package cache_ctrl_pkg;
  localparam int ICACHE_BYTES_DEFAULT = 4096;
  localparam int DCACHE_BYTES_DEFAULT = 2048;
  localparam int LINE_BYTES = 16;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int REGION_W = 4;
  localparam int REGIONS = 16;
  // region config bit positions
  localparam int CFG_CACHEABLE_BIT = 0;
  localparam int CFG_BIG_ENDIAN_BIT = 1;
  localparam int CFG_WIDTH_LSB = 2;
  localparam int CFG_W = 4;
  localparam logic [1:0] OFFS_ZERO = 2'h0;
  typedef enum logic [1:0] {
    IC_CMD_NONE,
    IC_CMD_PURGE,
    IC_CMD_LOCK,
    IC_CMD_UNLOCK
  } ic_cmd_type;
  typedef enum logic [1:0] {
    DC_CMD_NONE,
    DC_CMD_ENABLE,
    DC_CMD_DISABLE,
    DC_CMD_INVALIDATE
  } dc_cmd_type;
endpackage

/* core/valid_bits.sv */
// array of valid bits with bulk clear and registered lookup
module valid_bits #(
  parameter int ENTRIES = 64,
  parameter int IDX_W = 6
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clear_all,
  input wire logic set_en,
  input wire logic [IDX_W-1:0] set_idx,
  input wire logic clr_en,
  input wire logic [IDX_W-1:0] clr_idx,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic rd_valid
);
  logic [ENTRIES-1:0] valid_r;
  if (ENTRIES != (1 << IDX_W)) begin : g_bad_entries
    $error("valid_bits: ENTRIES must be 2**IDX_W");
  end
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : gen_v
      always_ff @(posedge clk) begin
        if (srst || clear_all) begin
          valid_r[g] <= 1'b0;
        end else if (set_en && set_idx == IDX_W'(g)) begin
          valid_r[g] <= 1'b1;
        end else if (clr_en && clr_idx == IDX_W'(g)) begin
          valid_r[g] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= valid_r[rd_idx];
    end
  end
endmodule

/* bench/cache_ctrl_monitor.sv */
// concurrent checks on the cache control ports
module cache_ctrl_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic ic_cmd_valid,
  input wire cache_ctrl_pkg::ic_cmd_type ic_cmd,
  input wire logic [31:0] ic_cmd_addr,
  input wire logic ic_busy,
  input wire logic ic_fill_req,
  input wire logic [31:0] ic_fill_addr,
  input wire logic ic_locked,
  input wire logic dc_cmd_valid,
  input wire cache_ctrl_pkg::dc_cmd_type dc_cmd,
  input wire logic dc_enabled,
  input wire logic [63:0] physical_region_config,
  input wire logic [63:0] logical_region_config,
  input wire logic dc_acc_valid,
  input wire logic [31:0] dc_acc_addr,
  input wire logic dc_acc_atomic,
  input wire logic dc_acc_aligned,
  input wire logic dc_cacheable,
  input wire logic dc_hit,
  input wire logic dc_big_endian,
  input wire logic [1:0] dc_bus_width,
  input wire logic dc_split
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic p_c;
  logic l_c;
  logic be_r;
  logic [1:0] w_r;
  assign p_c = physical_region_config[{dc_acc_addr[31:28], 2'h0}];
  assign l_c = logical_region_config[{dc_acc_addr[31:28], 2'h0}];
  // region attributes as they stood when the access was taken
  always_ff @(posedge clk) begin
    be_r <= physical_region_config[{dc_acc_addr[31:28], 2'h1}];
    w_r <= physical_region_config[{dc_acc_addr[31:28], 2'h2} +: 2];
  end
  a_atomic_uncached: assert property (dc_acc_valid && dc_acc_atomic |=> !dc_cacheable)
    else $error("atomic access cached");
  a_region_gate: assert property (dc_acc_valid && !(p_c && l_c) |=> !dc_cacheable)
    else $error("non-cacheable region cached");
  a_cache_allowed: assert property (
    dc_acc_valid && !dc_acc_atomic && p_c && l_c && dc_enabled && !dc_cmd_valid |=> dc_cacheable)
    else $error("cacheable access not cached");
  a_disabled_uncached: assert property (dc_acc_valid && !dc_enabled && !dc_cmd_valid |=> !dc_cacheable)
    else $error("cached while disabled");
  a_hit_needs_cache: assert property (dc_acc_valid |=> !dc_hit || dc_cacheable)
    else $error("hit on uncached piece");
  a_order_width: assert property (dc_acc_valid |=> dc_big_endian == be_r && dc_bus_width == w_r)
    else $error("byte order or width wrong");
  a_split_mark: assert property (dc_acc_valid |=> dc_split != $past(dc_acc_aligned))
    else $error("split flag wrong");
  a_enable_cmd: assert property (
    dc_cmd_valid && dc_cmd == cache_ctrl_pkg::DC_CMD_ENABLE |=> dc_enabled)
    else $error("enable ignored");
  a_disable_cmd: assert property (
    dc_cmd_valid && dc_cmd == cache_ctrl_pkg::DC_CMD_DISABLE |=> !dc_enabled)
    else $error("disable ignored");
  a_purge_unlock: assert property (
    ic_cmd_valid && ic_cmd == cache_ctrl_pkg::IC_CMD_PURGE && !ic_busy |=> !ic_locked)
    else $error("purge left lock");
  // the lock base is taken on a line boundary, so the low offset bits are dropped
  a_lock_start: assert property (
    ic_cmd_valid && ic_cmd == cache_ctrl_pkg::IC_CMD_LOCK && !ic_busy
    |=> ic_fill_req && ic_fill_addr == {$past(ic_cmd_addr[31:4]), 4'h0})
    else $error("lock fill not at operand");
  a_reset_state: assert property ($fell(srst) |-> !ic_locked && !dc_enabled)
    else $error("state after reset");
endmodule
////////////////////////////////////////////////////////////
bind cache_ctrl cache_ctrl_monitor cache_ctrl_monitor_inst (.clk, .srst, .ic_cmd_valid, .ic_cmd, .ic_cmd_addr,
  .ic_busy, .ic_fill_req, .ic_fill_addr, .ic_locked, .dc_cmd_valid, .dc_cmd, .dc_enabled, .physical_region_config,
  .logical_region_config, .dc_acc_valid, .dc_acc_addr, .dc_acc_atomic, .dc_acc_aligned, .dc_cacheable, .dc_hit,
  .dc_big_endian, .dc_bus_width, .dc_split);

/* bench/fill_responder.sv */
// external bus model answering instruction line fills
module fill_responder (
  input wire logic clk,
  input wire logic slow,
  input wire logic fill_req,
  output logic fill_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt = 0;
  logic pend = 1'b0;
  initial fill_done = 1'b0;
  // a request is a one-cycle pulse, so it is latched; the lock walk only
  // listens a cycle later, so the answer waits at least one cycle, slow mode three
  always @(negedge clk) begin
    if ((pend || fill_req) && wait_cnt >= (slow ? 3 : 1)) begin
      fill_done <= 1'b1;
      pend <= 1'b0;
      wait_cnt <= 0;
    end else begin
      fill_done <= 1'b0;
      pend <= pend || fill_req;
      wait_cnt <= (pend || fill_req) ? wait_cnt + 1 : 0;
    end
  end
endmodule

/* bench/instr_data_cache_control_tb.sv */
// self-checking bench for the cache control block
module instr_data_cache_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ICB = 2048;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ic_cmd_valid = 1'b0, ic_fetch_valid = 1'b0, dc_cmd_valid = 1'b0, dc_fill_valid = 1'b0, slow = 1'b0;
  logic dc_acc_valid = 1'b0, dc_acc_atomic = 1'b0, dc_acc_aligned = 1'b1;
  cache_ctrl_pkg::ic_cmd_type ic_cmd = cache_ctrl_pkg::IC_CMD_NONE;
  cache_ctrl_pkg::dc_cmd_type dc_cmd = cache_ctrl_pkg::DC_CMD_NONE;
  logic [31:0] ic_cmd_addr = 32'h0000_0000, ic_fetch_addr = 32'h0000_0000, dc_acc_addr = 32'h0000_0000;
  logic [31:0] dc_fill_addr = 32'h0000_0000, dc_raw_data = 32'h1122_3344, base = 32'h0000_1000;
  logic [63:0] phys = 64'h0000_0000_0000_7019;
  logic [63:0] logi = 64'h0000_0000_0000_1101;
  logic ic_busy, ic_hit, ic_lookup_done, ic_fill_req, ic_fill_done, ic_locked, dc_enabled;
  logic dc_cacheable, dc_hit, dc_big_endian, dc_split;
  logic [1:0] dc_bus_width;
  logic [31:0] ic_fill_addr, dc_data;
  int bad_count = 0, tests_run = 0, cyc = 0, fill_n = 0;
  cache_ctrl #(.ICACHE_BYTES(ICB), .DCACHE_BYTES(1024)) cache_ctrl_inst (.clk, .srst, .ic_cmd_valid, .ic_cmd,
    .ic_cmd_addr, .ic_busy, .ic_fetch_valid, .ic_fetch_addr, .ic_hit, .ic_lookup_done, .ic_fill_req, .ic_fill_addr,
    .ic_fill_done, .ic_locked, .dc_cmd_valid, .dc_cmd, .dc_enabled, .physical_region_config(phys),
    .logical_region_config(logi), .dc_acc_valid, .dc_acc_addr, .dc_acc_atomic, .dc_acc_aligned, .dc_fill_valid,
    .dc_fill_addr, .dc_raw_data, .dc_cacheable, .dc_hit, .dc_big_endian, .dc_bus_width, .dc_split, .dc_data);
  fill_responder fill_responder_inst (.clk, .slow, .fill_req(ic_fill_req), .fill_done(ic_fill_done));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    // lock fills counted at the request pulse; the answer arrives cycles later
    if (ic_fill_req && ic_busy) begin
      check(ic_fill_addr, base + 32'(16 * fill_n));
      fill_n++;
    end
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic dcmd(input cache_ctrl_pkg::dc_cmd_type c);
    @(negedge clk) {dc_cmd_valid, dc_cmd} = {1'b1, c};
    @(negedge clk) dc_cmd_valid = 1'b0;
  endtask
  task automatic icmd(input cache_ctrl_pkg::ic_cmd_type c, input logic [31:0] a);
    @(negedge clk) {ic_cmd_valid, ic_cmd, ic_cmd_addr} = {1'b1, c, a};
    @(negedge clk) ic_cmd_valid = 1'b0;
  endtask
  task automatic dfill(input logic [31:0] a);
    @(negedge clk) {dc_fill_valid, dc_fill_addr} = {1'b1, a};
    @(negedge clk) dc_fill_valid = 1'b0;
  endtask
  task automatic acc(input logic [31:0] a, input logic at, al, c, h);
    @(negedge clk) {dc_acc_valid, dc_acc_addr, dc_acc_atomic, dc_acc_aligned} = {1'b1, a, at, al};
    @(negedge clk) dc_acc_valid = 1'b0;
    check(dc_cacheable, c);
    check(dc_hit, h);
  endtask
  task automatic fetch(input logic [31:0] a, input logic h);
    @(negedge clk) {ic_fetch_valid, ic_fetch_addr} = {1'b1, a};
    @(negedge clk) ic_fetch_valid = 1'b0;
    check(ic_lookup_done, 1'b1);
    check(ic_hit, h);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_dcache();
    check({ic_locked, dc_enabled}, 2'h0);
    acc(32'h0000_0100, 1'b0, 1'b1, 1'b0, 1'b0);
    dcmd(cache_ctrl_pkg::DC_CMD_ENABLE);
    check(dc_enabled, 1'b1);
    acc(32'h0000_0100, 1'b0, 1'b1, 1'b1, 1'b0);
    dfill(32'h0000_0100);
    acc(32'h0000_0100, 1'b0, 1'b1, 1'b1, 1'b1);
    dcmd(cache_ctrl_pkg::DC_CMD_INVALIDATE);
    acc(32'h0000_0100, 1'b0, 1'b1, 1'b1, 1'b0);
    dcmd(cache_ctrl_pkg::DC_CMD_DISABLE);
    acc(32'h0000_0100, 1'b0, 1'b1, 1'b0, 1'b0);
    dcmd(cache_ctrl_pkg::DC_CMD_ENABLE);
    dcmd(cache_ctrl_pkg::DC_CMD_INVALIDATE);
  endtask
  task automatic t_region();
    for (int r = 0; r < 4; r++) begin
      acc({r[3:0], 28'h000_0200}, 1'b0, 1'b1, phys[4*r] & logi[4*r], 1'b0);
      check(dc_big_endian, phys[4*r+1]);
      check(dc_bus_width, phys[4*r+2 +: 2]);
      // raw word is fixed, so the byte-swapped form is a constant too
      check(dc_data, phys[4*r+1] ? 32'h4433_2211 : 32'h1122_3344);
    end
  endtask
  task automatic t_atomic_split();
    dfill(32'h0000_0300);
    acc(32'h0000_0300, 1'b1, 1'b1, 1'b0, 1'b0);
    acc(32'h0000_0300, 1'b0, 1'b0, 1'b1, 1'b1);
    check(dc_split, 1'b1);
    acc(32'h1000_0304, 1'b0, 1'b0, 1'b0, 1'b0);
    check(dc_split, 1'b1);
  endtask
  task automatic t_lock(input logic s);
    slow = s;
    fill_n = 0;
    icmd(cache_ctrl_pkg::IC_CMD_LOCK, base);
    for (int i = 0; i < 2000 && ic_locked !== 1'b1; i++) @(negedge clk);
    check({ic_locked, ic_busy}, 2'h2);
    check(fill_n, ICB / 2 / 16);
    fetch(base + 32'h0000_03F0, 1'b1);
    fetch(base + 32'(ICB / 2), 1'b0);
  endtask
  task automatic t_purge();
    icmd(cache_ctrl_pkg::IC_CMD_PURGE, 32'h0000_0000);
    check(ic_locked, 1'b0);
    fetch(base + 32'h0000_03F0, 1'b0);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_dcache();
    t_region();
    t_atomic_split();
    t_lock(1'b1);
    t_purge();
    t_lock(1'b0);
    @(negedge clk) srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    check({ic_locked, dc_enabled}, 2'h0);
    report_and_stop();
  end
endmodule
